// ### sensor_system_control_bench.sv
// self-checking bench for the system control block
`timescale 1ns/1ns
`default_nettype none
module sensor_system_control_bench;
  localparam logic [22:0] C = 23'd600; // shortened execution time
  logic clock, rst, cs_n, sclk, din, dout, ext_one, ext_two;
  logic one_in, one_out, one_oe, two_in, two_out, two_oe, trg;
  logic recording, record_start, record_toggle, record_escape;
  logic sup_hi, sup_lo, fl_fail, fl_sum, st_bad;
  logic [6:0] alarm;
  logic [15:0] cmd_start, seen, rdv;
  int mismatches, checks, busy_cycles, trig_n, esc_n, tog_n, n, b;
  int cmds[14] = '{0, 2, 3, 4, 5, 6, 7, 8, 9, 10, 12, 13, 14, 15};
  // wire level: whoever enables wins, else the outside driver
  assign one_in = one_oe ? one_out : ext_one;
  assign two_in = two_oe ? two_out : ext_two;
  ssc_host host (.cs_n(cs_n), .sclk(sclk), .din(din), .dout(dout));
  ssc_top #(.CYC_CLRNULL(C), .CYC_BAND(C), .CYC_RESTORE(C),
    .CYC_BANDSAVE(C), .CYC_BUFIDX(C), .CYC_BANDCLR(C), .CYC_CLRREC(C),
    .CYC_SWRST(C), .CYC_SAVE(C), .CYC_FLTEST(C), .CYC_DIAGCLR(C),
    .CYC_FACTORY(C), .CYC_SELFTEST(C), .CYC_AUTONULL(C)) dut (
    .clock(clock), .rst(rst), .cs_n(cs_n), .sclk(sclk), .din(din),
    .dout(dout), .aux_line_one_in(one_in), .aux_line_one_out(one_out),
    .aux_line_one_oe(one_oe), .aux_line_two_in(two_in),
    .aux_line_two_out(two_out), .aux_line_two_oe(two_oe),
    .recording(recording), .record_start(record_start),
    .alarm_flags(alarm), .supply_high(sup_hi), .supply_low(sup_lo),
    .flash_fail(fl_fail), .flash_sum_bad(fl_sum), .selftest_bad(st_bad),
    .flash_write_count(16'h5a3c), .cmd_start(cmd_start),
    .record_toggle(record_toggle), .record_escape(record_escape),
    .trigger_start(trg));
  initial
  begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  // tally pulses; the recording engine stops when escaped
  always @(posedge clock)
  begin
    seen <= seen | cmd_start;
    busy_cycles <= busy_cycles + int'(one_out && one_oe);
    trig_n <= trig_n + int'(trg);
    esc_n <= esc_n + int'(record_escape);
    tog_n <= tog_n + int'(record_toggle);
    if (record_escape)
      recording <= 1'b0;
  end
  task automatic summarize;
    if (mismatches == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic check(input string s, input logic [15:0] e,
                       input logic [15:0] g);
    checks++;
    if (g !== e)
    begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [15:0] r;
    host.xfer({1'b1, a, d}, 16, r);
  endtask
  // read answer comes back in the following frame
  task automatic rd(input logic [6:0] a, output logic [15:0] v);
    host.xfer({1'b0, a, 8'h00}, 16, v);
    host.xfer(16'h3c00, 16, v);
  endtask
  task automatic rc(input logic [6:0] a, input logic [15:0] e,
                    input string s);
    rd(a, rdv);
    check(s, e, rdv);
  endtask
  task automatic wait_ready;
    rdv = 16'h0000;
    for (int i = 0; i < 40 && rdv[7] !== 1'b1; i++)
      rd(7'h3c, rdv);
    check("ready", 16'h0080, rdv & 16'h0080);
  endtask
  task automatic pulse_two(input int len);
    @(posedge clock);
    ext_two <= 1'b1;
    repeat (len) @(posedge clock);
    ext_two <= 1'b0;
    repeat (12) @(posedge clock);
  endtask
  initial
  begin
    repeat (90000) @(posedge clock);
    mismatches++;
    summarize;
  end
  initial
  begin
    rst = 1'b1;
    {ext_one, ext_two, recording, record_start, seen} = '0;
    {sup_hi, sup_lo, fl_fail, fl_sum, st_bad, alarm} = 'h0;
    {mismatches, checks, busy_cycles, trig_n, esc_n, tog_n} = '0;
    repeat (12) @(posedge clock);
    rst <= 1'b0;
    repeat (4) @(posedge clock);
    check("busy idle", 16'h0002, {14'h0, one_oe, one_out});
    rc(7'h36, 16'h000f, "line config");
    rc(7'h38, 16'h0000, "general io");
    rc(7'h3c, 16'h0080, "status");
    rc(7'h00, 16'h5a3c, "flash count");
    rc(7'h20, 16'h0000, "unmapped");
    // every command pulses, holds busy for its time, then self-clears
    foreach (cmds[k])
    begin
      seen = 16'h0000;
      n = busy_cycles;
      wr(cmds[k] < 8 ? 7'h3e : 7'h3f, 8'h01 << (cmds[k] % 8));
      rc(7'h3c, 16'h0000, "busy flag");
      wait_ready;
      b = busy_cycles - n;
      check("cmd start", 16'h0001 << cmds[k], seen);
      check("busy span", 16'h0001, 16'(b >= C && b <= C + 4));
      wr(7'h36, 8'h0f);
    end
    wr(7'h3f, 8'h08);
    check("record request", 16'h0001, 16'(tog_n));
    // a write while busy must be dropped
    wr(7'h3f, 8'h01);
    wr(7'h36, 8'h2f);
    wait_ready;
    rc(7'h36, 16'h000f, "refused write");
    @(posedge clock);
    recording <= 1'b1;
    rdv = 16'h0000;
    for (int i = 0; i < 4 && rdv[7] !== 1'b1; i++)
    begin
      wr(7'h68, 8'he8);
      rd(7'h3c, rdv);
    end
    check("escape pulse", 16'h0001, 16'(esc_n));
    rc(7'h3c, 16'h0090, "escape flag");
    // flags are sticky after their causes go away
    @(posedge clock);
    {sup_hi, sup_lo, fl_fail, fl_sum, st_bad} <= 5'h1f;
    alarm <= 7'h01;
    repeat (5) @(posedge clock);
    {sup_hi, sup_lo, fl_fail, fl_sum, st_bad} <= 5'h00;
    alarm <= 7'h00;
    wr(7'h36, 8'h12);
    rc(7'h3c, 16'h01f7, "sticky flags");
    check("alarm line", 16'h0003, {14'h0, two_oe, two_out});
    @(posedge clock);
    record_start <= 1'b1;
    @(posedge clock);
    record_start <= 1'b0;
    rc(7'h3c, 16'h0080, "record clears");
    alarm <= 7'h10;
    wr(7'h36, 8'h17);
    wr(7'h34, 8'h40);
    alarm <= 7'h00;
    check("split lines", 16'h000b, {one_oe, one_out, two_oe, two_out});
    wr(7'h3e, 8'h10);
    wait_ready;
    check("lines cleared", 16'h000a, {one_oe, one_out, two_oe, two_out});
    wr(7'h36, 8'h2f);
    pulse_two(10);
    check("short trigger", 16'h0000, 16'(trig_n));
    pulse_two(27);
    check("trigger", 16'h0001, 16'(trig_n));
    wr(7'h36, 8'h00);
    wr(7'h38, 8'h03);
    wr(7'h39, 8'h01);
    check("general lines", 16'h000e, {one_oe, one_out, two_oe, two_out});
    host.xfer(16'h3c00, 15, rdv);
    rc(7'h3c, 16'h0088, "short frame");
    summarize;
  end
endmodule
`default_nettype wire

// ### ssc_aux_line.v
// one auxiliary line: function mux, polarity and trigger detect
`timescale 1ns/1ns
`default_nettype none
`include "ssc_defs.vh"
module ssc_aux_line (
  input wire clock, // system clock
  input wire rst, // async reset
  input wire [1:0] fn, // function select
  input wire pol, // 1 active high
  input wire gp_dir, // general mode: 1 output
  input wire gp_lvl, // general mode output level
  input wire alarm, // alarm condition
  input wire busy, // busy condition
  input wire pin_in, // synchronised pin level
  output reg pin_out, // pin drive level
  output reg pin_oe, // pin drive enable
  output reg trig // one-cycle trigger start pulse
);
  reg act_q;
  reg [7:0] hi_cnt_q;
  wire act_lvl;

  assign act_lvl = pol ? pin_in : ~pin_in;

  // output mux; polarity applied on active functions
  always @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      pin_out <= 1'b0;
      pin_oe <= 1'b0;
    end
    else
    begin
      case (fn)
        `SSC_FN_GPIO:
        begin
          pin_out <= gp_lvl;
          pin_oe <= gp_dir;
        end
        `SSC_FN_ALARM:
        begin
          pin_out <= ~(alarm ^ pol);
          pin_oe <= 1'b1;
        end
        `SSC_FN_BUSY:
        begin
          pin_out <= ~(busy ^ pol);
          pin_oe <= 1'b1;
        end
        default:
        begin
          pin_out <= 1'b0;
          pin_oe <= 1'b0;
        end
      endcase
    end
  end

  // trigger fires on the falling edge of a long enough pulse
  always @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      act_q <= 1'b0;
      hi_cnt_q <= 8'h00;
      trig <= 1'b0;
    end
    else
    begin
      act_q <= act_lvl;
      trig <= 1'b0;
      if (fn != `SSC_FN_TRIG)
        hi_cnt_q <= 8'h00;
      else if (act_lvl)
      begin
        if (hi_cnt_q != 8'hff)
          hi_cnt_q <= hi_cnt_q + 8'h01;
      end
      else
      begin
        if (act_q && hi_cnt_q >= `SSC_TRIG_MIN_CYC)
          trig <= 1'b1;
        hi_cnt_q <= 8'h00;
      end
    end
  end
endmodule
`default_nettype wire

// ### ssc_chk.sv
// assertions on the system control block ports
`timescale 1ns/1ns
`default_nettype none
module ssc_chk (
  input wire logic clock, // system clock
  input wire logic rst, // async reset, active high
  input wire logic aux_line_one_oe, // line one drive enable
  input wire logic aux_line_two_oe, // line two drive enable
  input wire logic [15:0] cmd_start, // command start pulses
  input wire logic record_toggle, // record request pulse
  input wire logic record_escape, // escape pulse
  input wire logic trigger_start // trigger start pulse
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);
  // a launch is one pulse followed by a quiet gap
  sequence s_launch;
    cmd_start != 16'h0000;
  endsequence
  sequence s_quiet;
    (cmd_start == 16'h0000) [*8];
  endsequence
  chk_cmd_one_pulse: assert property (s_launch |=> s_quiet)
    else $error("command start pulse not isolated");
  chk_cmd_one_bit: assert property ($onehot0(cmd_start))
    else $error("two commands started together");
  chk_cmd_no_reserved: assert property (!cmd_start[1] && !cmd_start[11])
    else $error("reserved command bit started");
  chk_trig_single: assert property (trigger_start |=> !trigger_start)
    else $error("trigger pulse longer than one cycle");
  chk_trig_line_input: assert property (
    trigger_start |-> !(aux_line_one_oe && aux_line_two_oe))
    else $error("trigger seen while both lines drive");
  chk_escape_single: assert property (record_escape |=> !record_escape)
    else $error("escape pulse longer than one cycle");
  chk_toggle_single: assert property (record_toggle |=> !record_toggle)
    else $error("record request longer than one cycle");
  chk_busy_after_rst: assert property ($fell(rst) |-> ##[0:3] aux_line_one_oe)
    else $error("line one not driving after reset");
endmodule
bind ssc_top ssc_chk u_chk (
  .clock(clock), .rst(rst), .aux_line_one_oe(aux_line_one_oe),
  .aux_line_two_oe(aux_line_two_oe), .cmd_start(cmd_start),
  .record_toggle(record_toggle), .record_escape(record_escape),
  .trigger_start(trigger_start)
);
`default_nettype wire

// ### ssc_defs.vh
// register map, field positions, reset values and timing counts
`ifndef SSC_DEFS_VH
`define SSC_DEFS_VH
`define SSC_ADDR_FLASH_COUNT 7'h00
`define SSC_ADDR_IO_CFG 7'h36
`define SSC_ADDR_IO_GEN 7'h38
`define SSC_ADDR_DIAG 7'h3c
`define SSC_ADDR_CMD 7'h3e
`define SSC_ADDR_ALM_SETUP 7'h34
`define SSC_ADDR_LOT1 7'h52
`define SSC_ADDR_LOT2 7'h54
`define SSC_ADDR_PROD 7'h56
`define SSC_ADDR_SERIAL 7'h58
`define SSC_IO_CFG_RST 16'h000f
`define SSC_IO_GEN_RST 16'h0000
`define SSC_DIAG_RST 16'h0000
`define SSC_WORD_STATUS_READ 16'h3c00
`define SSC_WORD_ESCAPE 16'he8e8
`define SSC_ESC_BYTE 8'he8
`define SSC_BIT_READY 7
`define SSC_BIT_FLASHSUM 6
`define SSC_BIT_SELFTEST 5
`define SSC_BIT_ESCAPE 4
`define SSC_BIT_SPIFAIL 3
`define SSC_BIT_FLASHFAIL 2
`define SSC_BIT_SUPHI 1
`define SSC_BIT_SUPLO 0
`define SSC_ALM_SPLIT_BIT 6
`define SSC_CLK_KHZ 10000
// execution times in whole microseconds, all scaled alike by SSC_CYC
`define SSC_T_CLRNULL_US 35
`define SSC_T_BAND_US 40
`define SSC_T_RESTORE_US 1900
`define SSC_T_BANDSAVE_US 461
`define SSC_T_BUFIDX_US 36
`define SSC_T_BANDCLR_US 25800
`define SSC_T_CLRREC_US 25900
`define SSC_T_SWRST_US 53300
`define SSC_T_SAVE_US 29300
`define SSC_T_FLTEST_US 5600
`define SSC_T_DIAGCLR_US 36
`define SSC_T_FACTORY_US 80900
`define SSC_T_SELFTEST_US 32900
`define SSC_T_AUTONULL_US 681000
`define SSC_T_TRIG_MIN_NS 2600
`define SSC_CLK_NS 100
`define SSC_CYC(us) ((us) * `SSC_CLK_KHZ / 1000)
`define SSC_TRIG_MIN_CYC ((`SSC_T_TRIG_MIN_NS + `SSC_CLK_NS - 1) / `SSC_CLK_NS)
`define SSC_FN_GPIO 2'b00
`define SSC_FN_ALARM 2'b01
`define SSC_FN_TRIG 2'b10
`define SSC_FN_BUSY 2'b11
`endif

// ### ssc_host.sv
// spi master model of the host processor, mode 3
`timescale 1ns/1ns
`default_nettype none
module ssc_host (
  output var logic cs_n, // chip select, active low
  output var logic sclk, // serial clock, idles high
  output var logic din, // data to the device
  input wire logic dout // data from the device
);
  localparam int HALF = 400; // 800 ns link period
  initial
  begin
    cs_n = 1'b1;
    sclk = 1'b1;
    din = 1'b0;
  end
  // one frame, msb first; odd offset keeps phase unrelated to clock
  task automatic xfer(input logic [15:0] w, input int nbits,
                      output logic [15:0] r);
    r = 16'h0000;
    #37 cs_n = 1'b0;
    for (int i = 0; i < nbits; i++)
    begin
      #HALF sclk = 1'b0;
      din = w[15 - i];
      #HALF sclk = 1'b1;
      r = {r[14:0], dout};
    end
    #HALF cs_n = 1'b1;
    din = ~din; // no valid level between frames
    #(2 * HALF);
  endtask
endmodule
`default_nettype wire

// ### ssc_sync.v
// two flip-flop synchroniser for one asynchronous level
`timescale 1ns/1ns
`default_nettype none
module ssc_sync #(
  parameter [0:0] RST_VAL = 1'b0 // reset level, the pin's idle level
) (
  input wire clock, // system clock
  input wire rst, // async reset, active high
  input wire d, // asynchronous level
  output reg q // synchronised level
);
  reg meta_q;

  // first stage feeds only the second
  always @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      meta_q <= RST_VAL;
      q <= RST_VAL;
    end
    else
    begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule
`default_nettype wire

// ### ssc_top.v
// system control block: spi slave, command engine, status, aux lines
// Summary of operation
// - command bits self-clear when function completes
// - bit 8 clears records in 25.9 ms
// - bit 14 loads alarm band, 40 us
// - bit 12 saves bands, bit 9 clears
// - bit 13 restores record in 1.9 ms
// - bit 6 saves registers in 29.3 ms
// - bit 5 flash test, mismatch to bit 6
// - other command bits with their times
// - error flags sticky until clear or record
// - status bits 8-14 are alarm flags
// - bit 3 flags clocks not multiple 16
// - bit 4 flags escape-interrupted recording
// - bits 1,0 supply, bit 2 flash fail
// - bit 7 zero busy, one ready
// - when busy only status read, escape
// - io config resets to busy output one
// - trigger pulse min 2.6 us, falling start
// - alarm line active on bits 8-13
// - split alarms per line when enabled
// - status clear returns alarm lines inactive
// - io config function and polarity fields
// - general io direction, level, input state
// - command bit 2 runs self-test, fails to bit5
`timescale 1ns/1ns
`default_nettype none
`include "ssc_defs.vh"
module ssc_top #(
  parameter [15:0] LOT1_VAL = 16'h0001, // arbitrary value
  parameter [15:0] LOT2_VAL = 16'h0002, // arbitrary value
  parameter [15:0] PROD_VAL = 16'h1234, // arbitrary value
  parameter [15:0] SERIAL_VAL = 16'h0005, // arbitrary value
  parameter [22:0] CYC_CLRNULL = `SSC_CYC(`SSC_T_CLRNULL_US),
  parameter [22:0] CYC_BAND = `SSC_CYC(`SSC_T_BAND_US),
  parameter [22:0] CYC_RESTORE = `SSC_CYC(`SSC_T_RESTORE_US),
  parameter [22:0] CYC_BANDSAVE = `SSC_CYC(`SSC_T_BANDSAVE_US),
  parameter [22:0] CYC_BUFIDX = `SSC_CYC(`SSC_T_BUFIDX_US),
  parameter [22:0] CYC_BANDCLR = `SSC_CYC(`SSC_T_BANDCLR_US),
  parameter [22:0] CYC_CLRREC = `SSC_CYC(`SSC_T_CLRREC_US),
  parameter [22:0] CYC_SWRST = `SSC_CYC(`SSC_T_SWRST_US),
  parameter [22:0] CYC_SAVE = `SSC_CYC(`SSC_T_SAVE_US),
  parameter [22:0] CYC_FLTEST = `SSC_CYC(`SSC_T_FLTEST_US),
  parameter [22:0] CYC_DIAGCLR = `SSC_CYC(`SSC_T_DIAGCLR_US),
  parameter [22:0] CYC_FACTORY = `SSC_CYC(`SSC_T_FACTORY_US),
  parameter [22:0] CYC_SELFTEST = `SSC_CYC(`SSC_T_SELFTEST_US),
  parameter [22:0] CYC_AUTONULL = `SSC_CYC(`SSC_T_AUTONULL_US)
) (
  input wire clock, // 10 MHz system clock
  input wire rst, // async reset, active high
  input wire cs_n, // spi chip select, active low
  input wire sclk, // spi clock from host
  input wire din, // spi data in
  output reg dout, // spi data out
  input wire aux_line_one_in, // line one pin level
  output wire aux_line_one_out, // line one drive level
  output wire aux_line_one_oe, // line one drive enable
  input wire aux_line_two_in, // line two pin level
  output wire aux_line_two_out, // line two drive level
  output wire aux_line_two_oe, // line two drive enable
  input wire recording, // recording engine active
  input wire record_start, // new record event pulse
  input wire [6:0] alarm_flags, // z2 y2 x2 z1 y1 x1 system order
  input wire supply_high, // supply above upper limit
  input wire supply_low, // supply below lower limit
  input wire flash_fail, // flash update failed
  input wire flash_sum_bad, // checksum differs from factory
  input wire selftest_bad, // self-test failed
  input wire [15:0] flash_write_count, // flash write counter
  output reg [15:0] cmd_start, // one-cycle start pulse per command
  output reg record_toggle, // record start/stop request pulse
  output reg record_escape, // escape abort pulse
  output wire trigger_start // trigger recording start pulse
);
  localparam ST_IDLE = 1'b0;
  localparam ST_RUN = 1'b1;

  wire cs_s, sclk_s, din_s, l1_s, l2_s;
  reg sclk_d_q, cs_d_q;
  reg [15:0] sh_q;
  reg [15:0] out_q;
  reg [4:0] bit_cnt_q;
  reg [15:0] io_line_config_q;
  reg [15:0] io_general_control_q;
  reg [15:0] alarm_setup_q;
  reg [15:0] command_trigger_q;
  reg [15:0] diag_q;
  reg [15:0] diag_d;
  reg [6:0] rd_addr_q;
  reg [15:0] rd_data;
  reg [22:0] run_cnt_q; // autonull needs 23 bits of cycles
  reg [22:0] run_len;
  reg [3:0] cmd_idx;
  integer i;
  reg state_q;
  reg word_stb;
  reg esc_seen;
  wire busy;
  wire sclk_rise, sclk_fall, cs_end;
  wire [15:0] word;
  wire t1, t2;
  wire alarm_any, alm_split;

  // spi and aux line inputs cross two flops first
  // select and clock reset to idle high, so no false edge after reset
  ssc_sync #(.RST_VAL(1'b1)) u_cs (.clock(clock), .rst(rst), .d(cs_n),
    .q(cs_s));
  ssc_sync #(.RST_VAL(1'b1)) u_sck (.clock(clock), .rst(rst), .d(sclk),
    .q(sclk_s));
  ssc_sync u_din (.clock(clock), .rst(rst), .d(din), .q(din_s));
  ssc_sync u_l1 (.clock(clock), .rst(rst), .d(aux_line_one_in), .q(l1_s));
  ssc_sync u_l2 (.clock(clock), .rst(rst), .d(aux_line_two_in), .q(l2_s));

  assign sclk_rise = sclk_s & ~sclk_d_q & ~cs_s;
  assign sclk_fall = ~sclk_s & sclk_d_q & ~cs_s;
  assign cs_end = cs_s & ~cs_d_q;
  assign word = {sh_q[14:0], din_s};
  assign busy = (state_q == ST_RUN) | recording;

  // highest set command bit picks the execution time
  always @*
  begin
    cmd_idx = 4'h0;
    for (i = 0; i < 16; i = i + 1)
      if (command_trigger_q[i])
        cmd_idx = i[3:0];
    case (cmd_idx)
      4'hf: run_len = CYC_CLRNULL;
      4'he: run_len = CYC_BAND;
      4'hd: run_len = CYC_RESTORE;
      4'hc: run_len = CYC_BANDSAVE;
      4'ha: run_len = CYC_BUFIDX;
      4'h9: run_len = CYC_BANDCLR;
      4'h8: run_len = CYC_CLRREC;
      4'h7: run_len = CYC_SWRST;
      4'h6: run_len = CYC_SAVE;
      4'h5: run_len = CYC_FLTEST;
      4'h4: run_len = CYC_DIAGCLR;
      4'h3: run_len = CYC_FACTORY;
      4'h2: run_len = CYC_SELFTEST;
      4'h0: run_len = CYC_AUTONULL;
      default: run_len = 23'h000001;
    endcase
  end

  // spi word capture; reads answer on the following frame
  always @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      sclk_d_q <= 1'b1;
      cs_d_q <= 1'b1;
      sh_q <= 16'h0000;
      out_q <= 16'h0000;
      dout <= 1'b0;
      bit_cnt_q <= 5'h00;
      word_stb <= 1'b0;
      esc_seen <= 1'b0;
    end
    else
    begin
      sclk_d_q <= sclk_s;
      cs_d_q <= cs_s;
      word_stb <= 1'b0;
      esc_seen <= 1'b0;
      if (cs_s)
        bit_cnt_q <= 5'h00;
      if (sclk_rise)
      begin
        sh_q <= word;
        bit_cnt_q <= (bit_cnt_q == 5'h0f) ? 5'h00 : bit_cnt_q + 5'h01;
        if (bit_cnt_q == 5'h0f)
        begin
          word_stb <= 1'b1;
          esc_seen <= (word == `SSC_WORD_ESCAPE);
        end
      end
      if (sclk_fall)
      begin
        dout <= out_q[15];
        out_q <= {out_q[14:0], 1'b0};
      end
      if (cs_end)
      begin
        out_q <= rd_data;
        dout <= rd_data[15];
      end
    end
  end

  // read mux, unmapped addresses read zero
  always @*
  begin
    case (rd_addr_q)
      `SSC_ADDR_FLASH_COUNT: rd_data = flash_write_count;
      `SSC_ADDR_IO_CFG: rd_data = io_line_config_q;
      `SSC_ADDR_IO_GEN: rd_data = {io_general_control_q[15:4],
                                   l2_s, l1_s, io_general_control_q[1:0]};
      `SSC_ADDR_DIAG: rd_data = diag_q;
      `SSC_ADDR_ALM_SETUP: rd_data = alarm_setup_q;
      `SSC_ADDR_LOT1: rd_data = LOT1_VAL;
      `SSC_ADDR_LOT2: rd_data = LOT2_VAL;
      `SSC_ADDR_PROD: rd_data = PROD_VAL;
      `SSC_ADDR_SERIAL: rd_data = SERIAL_VAL;
      default: rd_data = 16'h0000;
    endcase
  end

  // decode words; writes are byte-wide, one byte per frame at its own address
  always @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      rd_addr_q <= 7'h00;
      io_line_config_q <= `SSC_IO_CFG_RST;
      io_general_control_q <= `SSC_IO_GEN_RST;
      alarm_setup_q <= 16'h0000;
      command_trigger_q <= 16'h0000;
      record_toggle <= 1'b0;
    end
    else
    begin
      record_toggle <= 1'b0;
      if (state_q == ST_RUN && run_cnt_q == 23'h000001)
        command_trigger_q[cmd_idx] <= 1'b0;
      // escape drops pending bits, else the timer restarts them
      if (esc_seen && busy)
        command_trigger_q <= 16'h0000;
      if (word_stb && busy)
      begin
        if (sh_q == `SSC_WORD_STATUS_READ)
          rd_addr_q <= `SSC_ADDR_DIAG;
      end
      else if (word_stb && !sh_q[15])
        rd_addr_q <= {sh_q[14:9], 1'b0};
      else if (word_stb)
      begin
        case ({sh_q[14:8]})
          7'h36: io_line_config_q[7:0] <= sh_q[7:0];
          7'h37: io_line_config_q[15:8] <= sh_q[7:0];
          7'h38: io_general_control_q[7:0] <= {6'h00, sh_q[1:0]};
          7'h39: io_general_control_q[15:8] <= {6'h00, sh_q[1:0]};
          7'h34: alarm_setup_q[7:0] <= sh_q[7:0];
          7'h35: alarm_setup_q[15:8] <= sh_q[7:0];
          7'h3e: command_trigger_q[7:0] <= sh_q[7:0] & 8'hfd;
          7'h3f:
          begin
            command_trigger_q[15:8] <= sh_q[7:0] & 8'hf7;
            record_toggle <= sh_q[3];
          end
          default: rd_addr_q <= rd_addr_q;
        endcase
      end
    end
  end

  // command timer; one command at a time, lowest time slot last
  always @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      state_q <= ST_IDLE;
      run_cnt_q <= 23'h000000;
      cmd_start <= 16'h0000;
      record_escape <= 1'b0;
    end
    else
    begin
      cmd_start <= 16'h0000;
      record_escape <= esc_seen & busy;
      case (state_q)
        ST_IDLE:
          if (|command_trigger_q)
          begin
            state_q <= ST_RUN;
            run_cnt_q <= run_len;
            cmd_start[cmd_idx] <= 1'b1;
          end
        ST_RUN:
          if (esc_seen || run_cnt_q == 23'h000001)
          begin
            state_q <= ST_IDLE;
            run_cnt_q <= 23'h000000;
          end
          else
            run_cnt_q <= run_cnt_q - 23'h000001;
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // sticky status; events set over the clear in the same cycle
  always @*
  begin
    diag_d = diag_q;
    if ((state_q == ST_RUN && cmd_idx == 4'h4 && run_cnt_q == 23'h000001)
        || record_start)
      diag_d = `SSC_DIAG_RST;
    diag_d[14:8] = diag_d[14:8] | alarm_flags;
    if (supply_low)
      diag_d[`SSC_BIT_SUPLO] = 1'b1;
    if (supply_high)
      diag_d[`SSC_BIT_SUPHI] = 1'b1;
    if (flash_fail)
      diag_d[`SSC_BIT_FLASHFAIL] = 1'b1;
    if (cs_end && bit_cnt_q != 5'h00)
      diag_d[`SSC_BIT_SPIFAIL] = 1'b1;
    if (esc_seen && recording)
      diag_d[`SSC_BIT_ESCAPE] = 1'b1;
    if (selftest_bad)
      diag_d[`SSC_BIT_SELFTEST] = 1'b1;
    if (flash_sum_bad)
      diag_d[`SSC_BIT_FLASHSUM] = 1'b1;
    diag_d[`SSC_BIT_READY] = ~busy;
    diag_d[15] = 1'b0;
  end

  always @(posedge clock or posedge rst)
  begin
    if (rst)
      diag_q <= `SSC_DIAG_RST;
    else
      diag_q <= diag_d;
  end

  // alarm routing; split mode gives each line its own level
  assign alm_split = alarm_setup_q[`SSC_ALM_SPLIT_BIT];
  assign alarm_any = |diag_q[13:8];
  assign trigger_start = t1 | t2;

  ssc_aux_line u_line_one (
    .clock(clock),
    .rst(rst),
    .fn(io_line_config_q[3:2]),
    .pol(io_line_config_q[0]),
    .gp_dir(io_general_control_q[0]),
    .gp_lvl(io_general_control_q[8]),
    .alarm(alm_split ? |diag_q[10:8] : alarm_any),
    .busy(busy),
    .pin_in(l1_s),
    .pin_out(aux_line_one_out),
    .pin_oe(aux_line_one_oe),
    .trig(t1)
  );

  ssc_aux_line u_line_two (
    .clock(clock),
    .rst(rst),
    .fn(io_line_config_q[5:4]),
    .pol(io_line_config_q[1]),
    .gp_dir(io_general_control_q[1]),
    .gp_lvl(io_general_control_q[9]),
    .alarm(alm_split ? |diag_q[13:11] : alarm_any),
    .busy(busy),
    .pin_in(l2_s),
    .pin_out(aux_line_two_out),
    .pin_oe(aux_line_two_oe),
    .trig(t2)
  );
endmodule
`default_nettype wire
